// ===== core/cclc_device.sv
// Configuration device end: clock synthesis, power-on hold, byte output, flash arbitration
//
`timescale 1ns/1ps
`default_nettype none
`include "cclc_params.svh"
module cclc_device #(
  parameter int unsigned P_POR_SHORT_CYC = `CCLC_POR_SHORT_MS * `CCLC_CYC_PER_MS,
  parameter int unsigned P_POR_LONG_CYC  = `CCLC_POR_LONG_MS * `CCLC_CYC_PER_MS
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  cclc_link_if.dev               lnk,
  input  wire logic              i_clk_cfg_wr,
  input  wire logic              i_src_ext,
  input  wire cclc_pkg::cclc_osc_t i_osc_sel,
  input  wire logic [4:0]        i_div_n,
  input  wire logic              i_div_frac,
  input  wire logic              i_ext_clock_in,
  input  wire logic              i_por_long,
  input  wire logic [2:0]        i_page_select,
  input  wire logic              i_jtag_isp_busy,
  input  wire logic              i_hold_config_instr,
  input  wire logic              i_init_conf_instr,
  input  wire logic [7:0]        i_cfg_byte,
  input  wire logic              i_cfg_valid,
  input  wire logic              i_cfg_last,
  input  wire logic [15:0]       i_fl_dq_in,
  output logic                   o_cfg_start,
  output logic [2:0]             o_page,
  output logic                   o_cfg_take,
  output logic                   o_cfg_done,
  output logic                   o_cfg_error,
  output logic                   o_int_flash_own,
  output logic [20:0]            o_fl_addr,
  output logic [15:0]            o_fl_dq,
  output logic                   o_fl_dq_en,
  output logic                   o_fl_ce_n,
  output logic                   o_fl_oe_n,
  output logic                   o_fl_we_n
);
  import cclc_pkg::*;

  localparam int unsigned OSC10_CYC = (`CCLC_OSC10_HALF_PS + `CCLC_CLK_PS - 1) / `CCLC_CLK_PS;
  localparam int unsigned OSC33_CYC = (`CCLC_OSC33_HALF_PS + `CCLC_CLK_PS - 1) / `CCLC_CLK_PS;
  localparam int unsigned OSC50_CYC = (`CCLC_OSC50_HALF_PS + `CCLC_CLK_PS - 1) / `CCLC_CLK_PS;
  localparam int unsigned OSC66_CYC = (`CCLC_OSC66_HALF_PS + `CCLC_CLK_PS - 1) / `CCLC_CLK_PS;

  // ****************
  // Power-on hold
  // ****************
  logic [23:0] por_cnt_q;
  logic        por_done_q;
  logic [23:0] por_lim;
  logic        ctl_rst;

  assign por_lim = i_por_long ? 24'(P_POR_LONG_CYC) : 24'(P_POR_SHORT_CYC);
  // Low OE line from anyone keeps the controller and divider in reset
  assign ctl_rst = i_sys_rst | ~lnk.oe_line;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      por_cnt_q  <= 24'h000000;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      por_cnt_q  <= por_cnt_q + 24'h000001;
      por_done_q <= (por_cnt_q >= por_lim - 24'h000001);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      lnk.oe_dev_en <= 1'b1;
    end else begin
      lnk.oe_dev_en <= ~por_done_q;
    end
  end

  // ****************
  // Clock settings
  // ****************
  logic        src_ext_q;
  cclc_osc_t   osc_q;
  logic [4:0]  div_n_q;
  logic        div_frac_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      src_ext_q  <= `CCLC_RST_SRC_EXT;
      osc_q      <= CCLC_OSC_10;
      div_n_q    <= `CCLC_RST_DIV_N;
      div_frac_q <= 1'b0;
    end else if (i_clk_cfg_wr) begin
      src_ext_q  <= i_src_ext;
      osc_q      <= i_osc_sel;
      // Out-of-range factors clamp; fraction only exists for 1.5 and 2.5
      div_n_q    <= (i_div_n < `CCLC_DIV_MIN) ? `CCLC_DIV_MIN :
                    (i_div_n > `CCLC_DIV_MAX) ? `CCLC_DIV_MAX : i_div_n;
      div_frac_q <= i_div_frac && (i_div_n <= `CCLC_DIV_FRAC_MAX) &&
                    (i_div_n >= `CCLC_DIV_MIN);
    end
  end

  // ****************
  // Source: half-period ticks
  // ****************
  logic [2:0] osc_cnt_q;
  logic [2:0] osc_half;
  logic       osc_tick;
  logic       ext_q;
  logic       ext_prev_q;
  logic       src_tick;

  always_comb begin
    unique case (osc_q)
      CCLC_OSC_10: osc_half = 3'(OSC10_CYC);
      CCLC_OSC_33: osc_half = 3'(OSC33_CYC);
      CCLC_OSC_50: osc_half = 3'(OSC50_CYC);
      CCLC_OSC_66: osc_half = 3'(OSC66_CYC);
    endcase
  end

  assign osc_tick = (osc_cnt_q >= osc_half - 3'h1);

  always_ff @(posedge i_clk_sys) begin
    if (ctl_rst) begin
      osc_cnt_q <= 3'h0;
    end else begin
      osc_cnt_q <= osc_tick ? 3'h0 : osc_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ext_q      <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_q      <= i_ext_clock_in;
      ext_prev_q <= ext_q;
    end
  end

  // Both external edges count, so odd integer factors still split evenly
  assign src_tick = src_ext_q ? (ext_q ^ ext_prev_q) : osc_tick;

  // ****************
  // N divider
  // ****************
  logic [4:0] ph_cnt_q;
  logic [4:0] ph_len;
  logic       ph_end;
  logic       clk_fall;
  logic       clk_rise;

  // High phase takes the extra half period of a fractional factor
  assign ph_len   = lnk.config_clock_out ? div_n_q + {4'h0, div_frac_q} : div_n_q;
  assign ph_end   = src_tick && (ph_cnt_q >= ph_len - 5'h01);
  assign clk_fall = ph_end && lnk.config_clock_out;
  assign clk_rise = ph_end && !lnk.config_clock_out;

  always_ff @(posedge i_clk_sys) begin
    if (ctl_rst) begin
      ph_cnt_q             <= 5'h00;
      lnk.config_clock_out <= 1'b0;
    end else if (src_tick) begin
      ph_cnt_q             <= ph_end ? 5'h00 : ph_cnt_q + 5'h01;
      lnk.config_clock_out <= lnk.config_clock_out ^ ph_end;
    end
  end

  // ****************
  // JTAG init request
  // ****************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      lnk.init_request_od_en <= 1'b0;
    end else if (i_hold_config_instr) begin
      lnk.init_request_od_en <= 1'b1;
    end else if (i_init_conf_instr) begin
      lnk.init_request_od_en <= 1'b0;
    end
  end

  // ****************
  // Load sequence
  // ****************
  cclc_state_t state_q;
  logic        may_start;

  // Hold or ISP stops any internal flash use at once
  assign may_start = por_done_q && !lnk.init_request_od_en && !i_jtag_isp_busy;

  always_ff @(posedge i_clk_sys) begin
    if (ctl_rst) begin
      state_q <= CCLC_S_IDLE;
    end else begin
      unique case (state_q)
        CCLC_S_IDLE: begin
          if (may_start) begin
            state_q <= CCLC_S_SEND;
          end
        end
        CCLC_S_SEND: begin
          if (!may_start) begin
            state_q <= CCLC_S_IDLE;
          end else if (lnk.fpga_done_flag) begin
            state_q <= CCLC_S_DONE;
          end else if (clk_fall && i_cfg_valid && i_cfg_last) begin
            state_q <= CCLC_S_CHECK;
          end
        end
        CCLC_S_CHECK: begin
          // One full clock after the last byte the FPGA must report done
          if (lnk.fpga_done_flag) begin
            state_q <= CCLC_S_DONE;
          end else if (clk_fall) begin
            state_q <= CCLC_S_ERR;
          end
        end
        CCLC_S_DONE: state_q <= CCLC_S_DONE;
        CCLC_S_ERR:  state_q <= CCLC_S_ERR;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (ctl_rst) begin
      o_cfg_start <= 1'b0;
      o_cfg_take  <= 1'b0;
      o_cfg_done  <= 1'b0;
      o_cfg_error <= 1'b0;
    end else begin
      o_cfg_start <= (state_q == CCLC_S_IDLE) && may_start;
      o_cfg_take  <= (state_q == CCLC_S_SEND) && may_start && clk_fall && i_cfg_valid;
      o_cfg_done  <= (state_q == CCLC_S_DONE);
      o_cfg_error <= (state_q == CCLC_S_ERR);
    end
  end

  // Page survives controller reset so software can read it afterwards
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_page <= 3'h0;
    end else if (!ctl_rst && state_q == CCLC_S_IDLE && may_start) begin
      o_page <= i_page_select;
    end
  end

  // A starved source repeats the old byte; the reader must keep pace
  always_ff @(posedge i_clk_sys) begin
    if (ctl_rst) begin
      lnk.data <= 8'h00;
    end else if (state_q == CCLC_S_SEND && clk_fall && i_cfg_valid) begin
      lnk.data <= i_cfg_byte;
    end
  end

  // ****************
  // Flash arbitration
  // ****************
  logic int_own;
  logic ext_ok;

  assign int_own = (state_q == CCLC_S_SEND) && may_start && !ctl_rst;
  assign ext_ok  = !int_own && !i_jtag_isp_busy;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_int_flash_own <= 1'b0;
      lnk.ext_avail   <= 1'b0;
    end else begin
      o_int_flash_own <= int_own;
      lnk.ext_avail   <= ext_ok;
    end
  end

  // Internal side tri-stated: outer master drives the flash pins
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !lnk.ext_avail) begin
      o_fl_addr   <= 21'h000000;
      o_fl_dq     <= 16'h0000;
      o_fl_dq_en  <= 1'b0;
      o_fl_ce_n   <= 1'b1;
      o_fl_oe_n   <= 1'b1;
      o_fl_we_n   <= 1'b1;
      lnk.fl_dq_d <= 16'h0000;
    end else begin
      o_fl_addr   <= lnk.fl_addr;
      o_fl_dq     <= lnk.fl_dq_h;
      o_fl_dq_en  <= lnk.fl_dq_h_en;
      o_fl_ce_n   <= lnk.fl_ce_n;
      o_fl_oe_n   <= lnk.fl_oe_n;
      o_fl_we_n   <= lnk.fl_we_n;
      lnk.fl_dq_d <= i_fl_dq_in;
    end
  end
endmodule
`default_nettype wire

// ===== core/cclc_params.svh
// Constants of the configuration clock and load controller
`ifndef CCLC_PARAMS_SVH
`define CCLC_PARAMS_SVH
// ****************
// System clock
// ****************
`define CCLC_CLK_PS         10000
`define CCLC_CYC_PER_MS     100000
// ****************
// Oscillator half periods, rounded so no setting runs fast
// ****************
`define CCLC_OSC10_HALF_PS  50000
`define CCLC_OSC33_HALF_PS  15152
`define CCLC_OSC50_HALF_PS  10000
`define CCLC_OSC66_HALF_PS  7576
// ****************
// Power-on hold and divider
// ****************
`define CCLC_POR_SHORT_MS   2
`define CCLC_POR_LONG_MS    100
`define CCLC_DIV_MIN        5'h01
`define CCLC_DIV_MAX        5'h10
`define CCLC_DIV_FRAC_MAX   5'h02
`define CCLC_RST_DIV_N      5'h01
`define CCLC_RST_SRC_EXT    1'b0
`endif

// ===== core/cclc_pkg.sv
// Types of the configuration clock and load controller
package cclc_pkg;
  typedef enum logic [1:0] {
    CCLC_OSC_10 = 2'h0,
    CCLC_OSC_33 = 2'h1,
    CCLC_OSC_50 = 2'h2,
    CCLC_OSC_66 = 2'h3
  } cclc_osc_t;
  typedef enum logic [4:0] {
    CCLC_S_IDLE  = 5'h01,
    CCLC_S_SEND  = 5'h02,
    CCLC_S_CHECK = 5'h04,
    CCLC_S_DONE  = 5'h08,
    CCLC_S_ERR   = 5'h10
  } cclc_state_t;
endpackage

// ===== core/cclc_link_if.sv
// Link between the configuration device and the FPGA / flash master
`timescale 1ns/1ps
`default_nettype none
interface cclc_link_if;
  logic        config_clock_out;
  logic [7:0]  data;
  logic        oe_dev_en;
  logic        oe_host_en;
  logic        oe_line;
  logic        init_request_od_en;
  logic        init_request_line;
  logic        fpga_done_flag;
  logic        ext_avail;
  logic [20:0] fl_addr;
  logic [15:0] fl_dq_h;
  logic        fl_dq_h_en;
  logic [15:0] fl_dq_d;
  logic        fl_ce_n;
  logic        fl_oe_n;
  logic        fl_we_n;
  // Open-drain wires with pull-ups
  assign oe_line           = ~(oe_dev_en | oe_host_en);
  assign init_request_line = ~init_request_od_en;
  modport dev (
    output config_clock_out, data, oe_dev_en, init_request_od_en, ext_avail, fl_dq_d,
    input  oe_line, fpga_done_flag, fl_addr, fl_dq_h, fl_dq_h_en, fl_ce_n, fl_oe_n, fl_we_n
  );
  modport host (
    input  config_clock_out, data, oe_line, init_request_line, ext_avail, fl_dq_d,
    output oe_host_en, fpga_done_flag, fl_addr, fl_dq_h, fl_dq_h_en, fl_ce_n, fl_oe_n,
    output fl_we_n
  );
endinterface
`default_nettype wire

// ===== core/cclc_host.sv
// FPGA configuration port and external flash master end
`timescale 1ns/1ps
`default_nettype none
`include "cclc_params.svh"
module cclc_host (
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  cclc_link_if.host        lnk,
  input  wire logic        i_cfg_request,
  input  wire logic        i_fpga_done,
  input  wire logic        i_ext_req,
  input  wire logic [20:0] i_fl_addr,
  input  wire logic [15:0] i_fl_dq,
  input  wire logic        i_fl_dq_en,
  input  wire logic        i_fl_ce_n,
  input  wire logic        i_fl_oe_n,
  input  wire logic        i_fl_we_n,
  output logic             o_req_active,
  output logic [7:0]       o_byte,
  output logic             o_byte_valid,
  output logic             o_fl_grant,
  output logic [15:0]      o_fl_dq_rd
);
  import cclc_pkg::*;

  // ****************
  // Configuration request
  // ****************
  logic req;
  logic grant;

  // External flash access is won by holding the OE line low
  assign req   = i_cfg_request || i_ext_req || !lnk.init_request_line;
  assign grant = i_ext_req && lnk.ext_avail && !lnk.oe_line;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_req_active       <= 1'b0;
      lnk.oe_host_en     <= 1'b0;
      lnk.fpga_done_flag <= 1'b0;
    end else begin
      o_req_active       <= req;
      lnk.oe_host_en     <= req;
      lnk.fpga_done_flag <= !req && i_fpga_done;
    end
  end

  // ****************
  // Data capture
  // ****************
  logic clk_prev_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      clk_prev_q   <= 1'b0;
      o_byte       <= 8'h00;
      o_byte_valid <= 1'b0;
    end else begin
      clk_prev_q   <= lnk.config_clock_out;
      o_byte_valid <= lnk.config_clock_out && !clk_prev_q && !req;
      if (lnk.config_clock_out && !clk_prev_q) begin
        o_byte <= lnk.data;
      end
    end
  end

  // ****************
  // External flash master
  // ****************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !grant) begin
      o_fl_grant     <= 1'b0;
      lnk.fl_addr    <= 21'h000000;
      lnk.fl_dq_h    <= 16'h0000;
      lnk.fl_dq_h_en <= 1'b0;
      lnk.fl_ce_n    <= 1'b1;
      lnk.fl_oe_n    <= 1'b1;
      lnk.fl_we_n    <= 1'b1;
    end else begin
      o_fl_grant     <= 1'b1;
      lnk.fl_addr    <= i_fl_addr;
      lnk.fl_dq_h    <= i_fl_dq;
      lnk.fl_dq_h_en <= i_fl_dq_en;
      lnk.fl_ce_n    <= i_fl_ce_n;
      lnk.fl_oe_n    <= i_fl_oe_n;
      lnk.fl_we_n    <= i_fl_we_n;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_fl_dq_rd <= 16'h0000;
    end else if (o_fl_grant) begin
      o_fl_dq_rd <= lnk.fl_dq_d;
    end
  end
endmodule
`default_nettype wire

// ===== sim/cclc_link_asserts.sv
// Concurrent checks on the link between the device and the FPGA end
`timescale 1ns/1ps
`default_nettype none
module cclc_link_asserts #(
  parameter int unsigned P_POR_SHORT_CYC = 20,
  parameter int unsigned P_POR_LONG_CYC  = 50
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic       config_clock_out,
  input  wire logic [7:0] data,
  input  wire logic       oe_dev_en,
  input  wire logic       oe_line,
  input  wire logic       fpga_done_flag,
  input  wire logic       ext_avail
);
  int unsigned por_cnt_q;
  // ****************
  // Power-on hold length
  // ****************
  // Saturates so a stuck hold cannot wrap back into the legal window
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      por_cnt_q <= 0;
    end else if (oe_dev_en && por_cnt_q < P_POR_LONG_CYC + 8) begin
      por_cnt_q <= por_cnt_q + 1;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // ****************
  // Properties
  // ****************
  property p_por_release;
    $fell(oe_dev_en) |->
      (por_cnt_q + 2 >= P_POR_SHORT_CYC && por_cnt_q <= P_POR_SHORT_CYC + 3) ||
      (por_cnt_q + 2 >= P_POR_LONG_CYC && por_cnt_q <= P_POR_LONG_CYC + 3);
  endproperty
  a_por_release: assert property (p_por_release)
    else $error("OE released at a wrong count");
  property p_por_bound;
    oe_dev_en |-> por_cnt_q <= P_POR_LONG_CYC + 3;
  endproperty
  a_por_bound: assert property (p_por_bound)
    else $error("OE held beyond the long count");
  property p_oe_once;
    $rose(oe_dev_en) |-> $past(i_sys_rst);
  endproperty
  a_oe_once: assert property (p_oe_once)
    else $error("OE pulled again without reset");
  property p_data_on_fall;
    $changed(data) && $past(oe_line) && !$past(i_sys_rst) |-> $fell(config_clock_out);
  endproperty
  a_data_on_fall: assert property (p_data_on_fall)
    else $error("Data changed away from a clock fall");
  property p_clk_held;
    !oe_line |=> !config_clock_out;
  endproperty
  a_clk_held: assert property (p_clk_held)
    else $error("Clock ran while OE line low");
  property p_start_wait;
    $rose(oe_line) |-> !config_clock_out ##1 $stable(data);
  endproperty
  a_start_wait: assert property (p_start_wait)
    else $error("Clock started before OE line seen high");
  property p_no_ext_send;
    $changed(data) && $past(oe_line) && !$past(i_sys_rst) |-> !ext_avail;
  endproperty
  a_no_ext_send: assert property (p_no_ext_send)
    else $error("Flash offered outside while sending");
  property p_done_stops;
    (fpga_done_flag && oe_line) [*3] |-> $stable(data);
  endproperty
  a_done_stops: assert property (p_done_stops)
    else $error("Data moved after done flag");
  c_fall: cover property ($fell(config_clock_out));
  c_por: cover property ($fell(oe_dev_en));
  c_ext: cover property (ext_avail && !oe_line);
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Bench joining both ends of the configuration link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cclc_pkg::*;
  localparam int unsigned P_SHORT = 20;
  localparam int unsigned P_LONG  = 50;
  // Steps: external, oscillator, N, fraction, high and low cycles
  localparam int K_EXT [9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
  localparam int K_OSC [9] = '{0, 1, 2, 3, 2, 2, 2, 2, 2};
  localparam int K_N   [9] = '{1, 1, 1, 1, 16, 3, 1, 2, 2};
  localparam int K_FR  [9] = '{0, 0, 0, 0, 0, 0, 1, 1, 0};
  localparam int K_HI  [9] = '{5, 2, 1, 1, 16, 3, 2, 3, 6};
  localparam int K_LO  [9] = '{5, 2, 1, 1, 16, 3, 1, 2, 6};
  logic        clk, rst, cfg_wr, ext, frac, ext_clk, por_long, isp, hold, init;
  logic        cfg_req, done, ext_req, skip, cfg_last;
  logic        cfg_start, cfg_take, cfg_done, cfg_err, byte_vld, fl_grant;
  logic        int_own, req_act, fl_den_o, fl_ce_o, fl_oe_o, fl_we_o;
  logic [4:0]  div_n;
  logic [2:0]  page, page_o;
  logic [7:0]  src_b, last_b, exp_rx, rx_b;
  logic [20:0] fl_addr, fl_addr_o;
  logic [15:0] fl_dq, dq_rd, fl_dq_o;
  cclc_osc_t   osc;
  int          err_count, samples_checked, n, hi;
  cclc_link_if lnk ();
  cclc_device #(.P_POR_SHORT_CYC(P_SHORT), .P_POR_LONG_CYC(P_LONG)) cclc_device_i (
    .i_clk_sys(clk), .i_sys_rst(rst), .lnk(lnk.dev), .i_clk_cfg_wr(cfg_wr), .i_src_ext(ext),
    .i_osc_sel(osc), .i_div_n(div_n), .i_div_frac(frac), .i_ext_clock_in(ext_clk),
    .i_por_long(por_long), .i_page_select(page), .i_jtag_isp_busy(isp),
    .i_hold_config_instr(hold), .i_init_conf_instr(init), .i_cfg_byte(src_b),
    .i_cfg_valid(1'b1), .i_cfg_last(cfg_last), .i_fl_dq_in(fl_dq), .o_cfg_start(cfg_start),
    .o_page(page_o), .o_cfg_take(cfg_take), .o_cfg_done(cfg_done), .o_cfg_error(cfg_err),
    .o_int_flash_own(int_own), .o_fl_addr(fl_addr_o), .o_fl_dq(fl_dq_o),
    .o_fl_dq_en(fl_den_o), .o_fl_ce_n(fl_ce_o), .o_fl_oe_n(fl_oe_o), .o_fl_we_n(fl_we_o));
  cclc_host cclc_host_i (
    .i_clk_sys(clk), .i_sys_rst(rst), .lnk(lnk.host), .i_cfg_request(cfg_req),
    .i_fpga_done(done), .i_ext_req(ext_req), .i_fl_addr(fl_addr), .i_fl_dq(fl_dq),
    .i_fl_dq_en(1'b1), .i_fl_ce_n(1'b0), .i_fl_oe_n(1'b1), .i_fl_we_n(1'b0),
    .o_req_active(req_act), .o_byte(rx_b), .o_byte_valid(byte_vld), .o_fl_grant(fl_grant),
    .o_fl_dq_rd(dq_rd));
  cclc_link_asserts #(.P_POR_SHORT_CYC(P_SHORT), .P_POR_LONG_CYC(P_LONG)) asserts_i (
    .i_clk_sys(clk), .i_sys_rst(rst), .config_clock_out(lnk.config_clock_out),
    .data(lnk.data), .oe_dev_en(lnk.oe_dev_en), .oe_line(lnk.oe_line),
    .fpga_done_flag(lnk.fpga_done_flag), .ext_avail(lnk.ext_avail));
  assign cfg_last = (src_b == last_b);
  // ****************
  // Clocks, byte source and receive check
  // ****************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always begin
    repeat (3) @(posedge clk);
    ext_clk <= ~ext_clk;
  end
  always @(posedge clk) begin
    if (cfg_start === 1'b1) begin
      src_b <= 8'h01;
    end else if (cfg_take === 1'b1) begin
      src_b <= src_b + 8'h01;
    end
  end
  // First capture of a stream sees the byte left from before the start
  always @(posedge clk) begin
    if (cfg_start === 1'b1) begin
      exp_rx <= 8'h01;
      skip   <= 1'b1;
    end else if (byte_vld === 1'b1) begin
      if (!skip) begin
        chk("rx_byte", exp_rx, rx_b);
        exp_rx <= exp_rx + 8'h01;
      end
      skip <= 1'b0;
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wl(input logic v);
    n = 0;
    while (lnk.config_clock_out !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic meas(input int h, input int l);
    wl(1'b0);
    wl(1'b1);
    wl(1'b0);
    wl(1'b1);
    wl(1'b0);
    hi = n;
    wl(1'b1);
    chk("clk_high", h, hi);
    chk("clk_low", l, n);
  endtask
  task automatic setclk(input int i);
    ext    <= (K_EXT[i] != 0);
    osc    <= cclc_osc_t'(K_OSC[i]);
    div_n  <= 5'(K_N[i]);
    frac   <= (K_FR[i] != 0);
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic do_rst(input logic lg, input int unsigned len);
    por_long <= lg;
    rst      <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    while (lnk.oe_line !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("por_len_ok", 1, n + 2 >= len && n <= len + 4);
  endtask
  task automatic wait_start();
    n = 0;
    while (cfg_start !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("cfg_start", 1, cfg_start);
  endtask
  task automatic quiet();
    hi = 0;
    repeat (30) begin
      @(posedge clk);
      hi += (cfg_start === 1'b1);
    end
  endtask
  // FPGA request pulls OE low; the flash is lent out meanwhile when asked
  task automatic restart(input logic fl);
    done    <= 1'b0;
    cfg_req <= 1'b1;
    if (fl) begin
      ext_req <= 1'b1;
      fl_addr <= 21'h1abcd;
      fl_dq   <= 16'hbeef;
      repeat (8) @(posedge clk);
      chk("fl_grant", 1, fl_grant);
      chk("fl_addr", 21'h1abcd, fl_addr_o);
      chk("fl_dq_rd", 16'hbeef, dq_rd);
      chk("fl_dq_pins", 16'hbeef, fl_dq_o);
      chk("fl_ctl_write", 4'ha, {fl_den_o, fl_ce_o, fl_oe_o, fl_we_o});
      chk("int_own_off", 0, int_own);
      isp <= 1'b1;
      repeat (4) @(posedge clk);
      chk("fl_grant_isp", 0, fl_grant);
      chk("fl_ctl_idle", 4'h7, {fl_den_o, fl_ce_o, fl_oe_o, fl_we_o});
      isp     <= 1'b0;
      ext_req <= 1'b0;
    end
    quiet();
    chk("start_while_low", 0, hi);
    chk("oe_line", 0, lnk.oe_line);
    chk("req_active", 1, req_act);
    cfg_req <= 1'b0;
    wait_start();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    rst = 1'b1;
    {cfg_wr, ext, frac, ext_clk, por_long, isp, hold, init} = 8'h00;
    {cfg_req, done, ext_req, skip} = 4'h1;
    div_n = 5'h01;
    page = 3'h5;
    osc = CCLC_OSC_10;
    src_b = 8'h01;
    last_b = 8'h00;
    exp_rx = 8'h01;
    fl_addr = 21'h000000;
    fl_dq = 16'h0000;
    err_count = 0;
    samples_checked = 0;
    do_rst(1'b1, P_LONG);
    do_rst(1'b0, P_SHORT);
    wait_start();
    chk("page", 3'h5, page_o);
    page <= 3'h2;
    $display("test power-on done");
    for (int i = 0; i < 9; i++) begin
      if (i > 0) setclk(i);
      meas(K_HI[i], K_LO[i]);
    end
    chk("page_kept", 3'h5, page_o);
    chk("int_flash_own", 1, int_own);
    $display("test clocking done");
    setclk(4);
    last_b <= src_b + 8'h03;
    n = 0;
    while (exp_rx !== last_b + 8'h01 && n < 600) begin
      @(posedge clk);
      n++;
    end
    done <= 1'b1;
    repeat (10) @(posedge clk);
    chk("rx_count", last_b + 8'h01, exp_rx);
    chk("cfg_done", 1, cfg_done);
    chk("cfg_err_clear", 0, cfg_err);
    $display("test done flag done");
    restart(1'b1);
    chk("page_new", 3'h2, page_o);
    // Stream restarts at byte one, so the third byte is the last
    last_b <= 8'h03;
    n = 0;
    while (!(cfg_take === 1'b1 && cfg_last === 1'b1) && n < 600) begin
      @(posedge clk);
      n++;
    end
    repeat (40) @(posedge clk);
    chk("cfg_err", 1, cfg_err);
    $display("test flash and error done");
    restart(1'b0);
    // Instruction updates stay many cycles apart, as a slow test clock gives
    hold <= 1'b1;
    @(posedge clk);
    hold <= 1'b0;
    repeat (2) @(posedge clk);
    chk("init_req_low", 0, lnk.init_request_line);
    quiet();
    chk("start_while_hold", 0, hi);
    init <= 1'b1;
    @(posedge clk);
    init <= 1'b0;
    repeat (2) @(posedge clk);
    chk("init_req_high", 1, lnk.init_request_line);
    wait_start();
    $display("test hold and initiate done");
    do_rst(1'b0, P_SHORT);
    summarize();
  end
  initial begin
    #200000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
